// >>> power_stage_model.sv
`timescale 1ns/100ps
module power_stage_model (
   // clock
   input wire logic clk,
   // gate drive from the block
   input wire logic [1:0] pwmHigh,
   input wire logic [1:0] pwmLow,
   // trip requests from the bench
   input wire logic [1:0] faultCmd,
   input wire logic [1:0] limitCmd,
   // sensor pins back to the block
   output logic [1:0] faultIn,
   output logic [1:0] limitIn,
   // leg 0 state
   output logic shootThrough,
   output logic legOff
);
   // a trip lasts four cycles so the pin synchroniser always sees it
   int faultCnt[2];
   int limitCnt[2];

   initial begin
      faultIn = 2'h0;
      limitIn = 2'h0;
      faultCnt = '{0, 0};
      limitCnt = '{0, 0};
   end

   always @(posedge clk) begin
      for (int g = 0; g < 2; g++) begin
         faultCnt[g] = faultCmd[g] ? 4 :
            (faultCnt[g] > 0 ? faultCnt[g] - 1 : 0);
         limitCnt[g] = limitCmd[g] ? 4 :
            (limitCnt[g] > 0 ? limitCnt[g] - 1 : 0);
         faultIn[g] <= faultCnt[g] > 0;
         limitIn[g] <= limitCnt[g] > 0;
      end
   end

   assign shootThrough = pwmHigh[0] & pwmLow[0];
   assign legOff = ~pwmHigh[0] & ~pwmLow[0];
endmodule

// >>> pwm_generator_unit.sv
`timescale 1ns/100ps
module pwm_generator_unit (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // settings
   input smps_pwm_pkg::gen_ctrl_type ctrl,
   input wire logic [15:0] genDuty,
   input wire logic [15:0] masterDuty,
   input wire logic [15:0] phase,
   input wire logic [15:0] deadTime,
   // primary time base
   input wire logic [15:0] primaryCount,
   input wire logic [15:0] primaryPeriod,
   // external reset source, one-cycle pulse
   input wire logic limitRise,
   // outputs
   output logic pwmHigh,
   output logic pwmLow,
   output logic trigEvent
);

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] activeDuty;
      logic rawLast;
      logic [11:0] dtCount;
      logic hi;
      logic lo;
      logic trig;
   } gen_state_type;

   gen_state_type s_q;
   gen_state_type s_d;
   logic [15:0] selDuty;
   logic [15:0] localPeriod;
   logic [16:0] shifted;
   logic [15:0] timebase;
   logic wrap;
   logic raw;
   logic busy;

   always_comb begin
      s_d = s_q;
      selDuty = ctrl.masterDutySel ? masterDuty : genDuty;
      localPeriod = phase & smps_pwm_pkg::ITB_PERIOD_MASK;
      shifted = {1'b0, primaryCount} +
         {1'b0, phase & smps_pwm_pkg::PHASE_MASK};
      if (shifted > {1'b0, primaryPeriod}) begin
         shifted = shifted - {1'b0, primaryPeriod} - 17'h00001;
      end
      if (ctrl.independentTimebaseSel) begin
         timebase = s_q.count;
         wrap = s_q.count >= localPeriod;
         if (ctrl.externalTimebaseReset && limitRise) begin
            s_d.count = 16'h0000;
         end else if (wrap) begin
            s_d.count = 16'h0000;
         end else begin
            s_d.count = s_q.count + 16'h0001;
         end
      end else begin
         timebase = shifted[15:0];
         wrap = timebase == primaryPeriod;
         s_d.count = 16'h0000;
      end
      if (ctrl.immediateUpdate || wrap) begin
         s_d.activeDuty = selDuty;
      end
      raw = timebase < s_q.activeDuty;
      if (raw != s_q.rawLast) begin
         s_d.rawLast = raw;
         s_d.dtCount = deadTime[13:2];
      end else if (s_q.dtCount != 12'h000) begin
         s_d.dtCount = s_q.dtCount - 12'h001;
      end
      busy = s_d.dtCount != 12'h000;
      // dead-time modes, reserved acts as off
      case (ctrl.deadTimeCtrl)
         smps_pwm_pkg::DT_POSITIVE: begin
            s_d.hi = raw & ~busy;
            s_d.lo = ~raw & ~busy;
         end
         smps_pwm_pkg::DT_NEGATIVE: begin
            s_d.hi = raw | busy;
            s_d.lo = ~raw | busy;
         end
         default: begin
            s_d.hi = raw;
            s_d.lo = ~raw;
         end
      endcase
      s_d.trig = wrap;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pwmHigh = s_q.hi;
   assign pwmLow = s_q.lo;
   assign trigEvent = s_q.trig;

endmodule

// >>> smps_pwm_generator_core_regs.sv
`timescale 1ns/100ps
module smps_pwm_generator_core_regs (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [smps_pwm_pkg::ADDR_W-1:0] regAddr,
   input wire logic [smps_pwm_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [smps_pwm_pkg::DATA_W-1:0] regRdata,
   // fault and current-limit pins
   input wire logic [smps_pwm_pkg::NUM_GEN-1:0] faultIn,
   input wire logic [smps_pwm_pkg::NUM_GEN-1:0] limitIn,
   // power-stage outputs
   output logic [smps_pwm_pkg::NUM_GEN-1:0] pwmHigh,
   output logic [smps_pwm_pkg::NUM_GEN-1:0] pwmLow,
   // interrupt requests and event trigger
   output logic [smps_pwm_pkg::NUM_GEN-1:0] genIrq,
   output logic eventTrigger
);

   localparam int N = smps_pwm_pkg::NUM_GEN;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] period;
      logic [15:0] eventCmp;
      logic [15:0] masterDuty;
      logic [3:0] postscale;
      smps_pwm_pkg::gen_ctrl_type [N-1:0] ctrl;
      logic [N-1:0][15:0] duty;
      logic [N-1:0][15:0] phase;
      logic [N-1:0][15:0] deadTime;
      logic [N-1:0][2:0] faultSync;
      logic [N-1:0][2:0] limitSync;
      logic [N-1:0] faultLvl;
      logic [N-1:0] limitLvl;
      logic [N-1:0] faultRise;
      logic [N-1:0] limitRise;
      logic [15:0] count;
      logic [3:0] postCount;
      logic eventOut;
      logic [N-1:0] irq;
      logic [15:0] rdata;
   } core_state_type;

   core_state_type s_q;
   core_state_type s_d;
   smps_pwm_pkg::reg_req_type req;
   logic [N-1:0] genHigh;
   logic [N-1:0] genLow;
   logic [N-1:0] genTrig;
   logic [3:0] page;
   logic [3:0] offs;
   logic eventHit;
   logic [15:0] rd;

   assign req.addr = regAddr;
   assign req.wdata = regWdata;
   assign req.wr = regWr;
   assign req.rd = regRd;
   assign page = req.addr[7:4];
   assign offs = req.addr[3:0];

   // ----------------------------------------------------------------
   // generators
   // ----------------------------------------------------------------
   for (genvar g = 0; g < N; g++) begin : gen_unit
      pwm_generator_unit unit (
         .clk(clk),
         .resetn(resetn),
         .ctrl(s_q.ctrl[g]),
         .genDuty(s_q.duty[g]),
         .masterDuty(s_q.masterDuty),
         .phase(s_q.phase[g]),
         .deadTime(s_q.deadTime[g]),
         .primaryCount(s_q.count),
         .primaryPeriod(s_q.period),
         .limitRise(s_q.limitRise[g]),
         .pwmHigh(genHigh[g]),
         .pwmLow(genLow[g]),
         .trigEvent(genTrig[g])
      );
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      rd = 16'h0000;
      eventHit = 1'b0;

      // pin synchronisers; level moves once stages two and three agree
      for (int g = 0; g < N; g++) begin
         s_d.faultSync[g] = {s_q.faultSync[g][1:0], faultIn[g]};
         s_d.limitSync[g] = {s_q.limitSync[g][1:0], limitIn[g]};
         if (s_q.faultSync[g][1] == s_q.faultSync[g][2]) begin
            s_d.faultLvl[g] = s_q.faultSync[g][2];
         end
         if (s_q.limitSync[g][1] == s_q.limitSync[g][2]) begin
            s_d.limitLvl[g] = s_q.limitSync[g][2];
         end
         s_d.faultRise[g] = s_d.faultLvl[g] & ~s_q.faultLvl[g];
         s_d.limitRise[g] = s_d.limitLvl[g] & ~s_q.limitLvl[g];
      end

      if (s_q.count >= s_q.period) begin
         s_d.count = 16'h0000;
      end else begin
         s_d.count = s_q.count + 16'h0001;
      end

      eventHit = s_q.count == s_q.eventCmp;
      s_d.eventOut = 1'b0;
      if (eventHit) begin
         if (s_q.postCount >= s_q.postscale) begin
            s_d.postCount = 4'h0;
            s_d.eventOut = 1'b1;
         end else begin
            s_d.postCount = s_q.postCount + 4'h1;
         end
      end

      // ----------------------------------------------------------
      // register writes
      // ----------------------------------------------------------
      if (req.wr && page == smps_pwm_pkg::PAGE_SHARED) begin
         case (offs)
            smps_pwm_pkg::OFF_PERIOD: begin
               s_d.period = req.wdata & smps_pwm_pkg::PERIOD_MASK;
            end
            smps_pwm_pkg::OFF_EVENT_CMP: begin
               s_d.eventCmp = req.wdata & smps_pwm_pkg::EVENT_MASK;
            end
            smps_pwm_pkg::OFF_MASTER_DUTY: begin
               s_d.masterDuty = req.wdata;
            end
            smps_pwm_pkg::OFF_POSTSCALE: begin
               s_d.postscale = req.wdata[3:0];
               s_d.postCount = 4'h0;
            end
            default: begin
            end
         endcase
      end

      for (int g = 0; g < N; g++) begin
         if (req.wr && page == 4'(g + 1)) begin
            case (offs)
               smps_pwm_pkg::OFF_CTRL: begin
                  // status bits are hardware owned, not written
                  s_d.ctrl[g] = (req.wdata & smps_pwm_pkg::CTRL_WR_MASK)
                     | (s_q.ctrl[g] & ~smps_pwm_pkg::CTRL_WR_MASK);
               end
               smps_pwm_pkg::OFF_DUTY: begin
                  s_d.duty[g] = req.wdata;
               end
               smps_pwm_pkg::OFF_PHASE: begin
                  s_d.phase[g] = req.wdata & smps_pwm_pkg::PHASE_MASK;
               end
               smps_pwm_pkg::OFF_DEAD: begin
                  s_d.deadTime[g] = req.wdata & smps_pwm_pkg::DEAD_MASK;
               end
               default: begin
               end
            endcase
         end

         // ----------------------------------------------------------
         // pending status; a disabling write clears even a new event
         // ----------------------------------------------------------
         // fault, limit and trigger pending
         s_d.ctrl[g].faultPending = (s_q.ctrl[g].faultPending |
            s_q.faultRise[g]) & s_d.ctrl[g].faultIrqEn;
         s_d.ctrl[g].limitPending = (s_q.ctrl[g].limitPending |
            s_q.limitRise[g]) & s_d.ctrl[g].limitIrqEn;
         s_d.ctrl[g].triggerPending = (s_q.ctrl[g].triggerPending |
            genTrig[g]) & s_d.ctrl[g].triggerIrqEn;
         s_d.irq[g] = s_d.ctrl[g].faultPending |
            s_d.ctrl[g].limitPending | s_d.ctrl[g].triggerPending;
      end

      // ----------------------------------------------------------
      // register reads, unmapped reads as zero
      // ----------------------------------------------------------
      if (req.rd && page == smps_pwm_pkg::PAGE_SHARED) begin
         case (offs)
            smps_pwm_pkg::OFF_PERIOD: begin
               rd = s_q.period;
            end
            smps_pwm_pkg::OFF_EVENT_CMP: begin
               rd = s_q.eventCmp;
            end
            smps_pwm_pkg::OFF_MASTER_DUTY: begin
               rd = s_q.masterDuty;
            end
            smps_pwm_pkg::OFF_POSTSCALE: begin
               rd = {12'h000, s_q.postscale};
            end
            smps_pwm_pkg::OFF_COUNT: begin
               rd = s_q.count;
            end
            default: begin
               rd = 16'h0000;
            end
         endcase
      end
      for (int g = 0; g < N; g++) begin
         if (req.rd && page == 4'(g + 1)) begin
            case (offs)
               smps_pwm_pkg::OFF_CTRL: begin
                  rd = s_q.ctrl[g] & 16'hFFC3;
               end
               smps_pwm_pkg::OFF_DUTY: begin
                  rd = s_q.duty[g];
               end
               smps_pwm_pkg::OFF_PHASE: begin
                  rd = s_q.phase[g];
               end
               smps_pwm_pkg::OFF_DEAD: begin
                  rd = s_q.deadTime[g];
               end
               default: begin
                  rd = 16'h0000;
               end
            endcase
         end
      end
      // read data stands one cycle only
      s_d.rdata = rd;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // duty range kept by software, no clamping here
   assign pwmHigh = genHigh;
   assign pwmLow = genLow;
   assign genIrq = s_q.irq;
   assign eventTrigger = s_q.eventOut;
   assign regRdata = s_q.rdata;

endmodule

// >>> smps_pwm_pkg.sv
package smps_pwm_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_GEN = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // ----------------------------------------------------------------
   // register map, shared block at page 0, generator g at page g+1
   // ----------------------------------------------------------------
   localparam logic [3:0] PAGE_SHARED = 4'h0;
   localparam logic [3:0] OFF_PERIOD = 4'h0;
   localparam logic [3:0] OFF_EVENT_CMP = 4'h1;
   localparam logic [3:0] OFF_MASTER_DUTY = 4'h2;
   localparam logic [3:0] OFF_POSTSCALE = 4'h3;
   localparam logic [3:0] OFF_COUNT = 4'h4;
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_DUTY = 4'h1;
   localparam logic [3:0] OFF_PHASE = 4'h2;
   localparam logic [3:0] OFF_DEAD = 4'h3;

   // ----------------------------------------------------------------
   // field masks and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] PERIOD_MASK = 16'hFFF8;
   localparam logic [15:0] EVENT_MASK = 16'hFFF8;
   localparam logic [15:0] PHASE_MASK = 16'hFFFC;
   localparam logic [15:0] ITB_PERIOD_MASK = 16'hFFF0;
   localparam logic [15:0] DEAD_MASK = 16'h3FFC;
   localparam logic [15:0] CTRL_WR_MASK = 16'h1FC3;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [3:0] POSTSCALE_RESET = 4'h0;
   localparam logic [15:0] DUTY_MIN = 16'h0008;
   localparam logic [15:0] DUTY_MAX = 16'hFFEF;

   // ----------------------------------------------------------------
   // dead-time modes
   // ----------------------------------------------------------------
   localparam logic [1:0] DT_POSITIVE = 2'h0;
   localparam logic [1:0] DT_NEGATIVE = 2'h1;
   localparam logic [1:0] DT_OFF = 2'h2;

   // generator control word, bit 15 first
   typedef struct packed {
      logic faultPending;
      logic limitPending;
      logic triggerPending;
      logic faultIrqEn;
      logic limitIrqEn;
      logic triggerIrqEn;
      logic independentTimebaseSel;
      logic masterDutySel;
      logic [1:0] deadTimeCtrl;
      logic [3:0] unused;
      logic externalTimebaseReset;
      logic immediateUpdate;
   } gen_ctrl_type;

   // register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

endpackage

// >>> smps_pwm_props.sv
`timescale 1ns/100ps
module smps_pwm_props (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [smps_pwm_pkg::ADDR_W-1:0] regAddr,
   input wire logic [smps_pwm_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [smps_pwm_pkg::DATA_W-1:0] regRdata,
   // pins
   input wire logic [smps_pwm_pkg::NUM_GEN-1:0] faultIn,
   input wire logic [smps_pwm_pkg::NUM_GEN-1:0] limitIn,
   input wire logic [smps_pwm_pkg::NUM_GEN-1:0] pwmHigh,
   input wire logic [smps_pwm_pkg::NUM_GEN-1:0] pwmLow,
   input wire logic [smps_pwm_pkg::NUM_GEN-1:0] genIrq,
   input wire logic eventTrigger
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // ----------------------------------------------------------------
   // register read-back
   // ----------------------------------------------------------------
   a_period_lowbits: assert property (
      regRd && regAddr == 8'h00 |=> regRdata[2:0] == 3'h0)
      else $error("period low bits not zero");
   a_event_lowbits: assert property (
      regRd && regAddr == 8'h01 |=> regRdata[2:0] == 3'h0)
      else $error("event compare low bits not zero");
   a_master_full: assert property (
      regWr && regAddr == 8'h02 ##1 regRd && regAddr == 8'h02
      |=> regRdata == $past(regWdata, 2))
      else $error("master duty lost bits");
   a_duty_full: assert property (
      regWr && regAddr == 8'h11 ##1 regRd && regAddr == 8'h11
      |=> regRdata == $past(regWdata, 2))
      else $error("generator duty lost bits");
   a_phase_lowbits: assert property (
      regRd && regAddr[3:0] == 4'h2 && regAddr[7:4] inside {4'h1, 4'h2}
      |=> regRdata[1:0] == 2'h0)
      else $error("phase low bits not zero");
   a_dead_bits: assert property (
      regRd && regAddr[3:0] == 4'h3 && regAddr[7:4] inside {4'h1, 4'h2}
      |=> regRdata[15:14] == 2'h0 && regRdata[1:0] == 2'h0)
      else $error("dead time unused bits not zero");

   // ----------------------------------------------------------------
   // pending status and request
   // ----------------------------------------------------------------
   // disabling all three must wipe status even if set just before
   a_status_clear: assert property (
      regWr && regAddr == 8'h10 && regWdata[12:10] == 3'h0
      ##1 regRd && regAddr == 8'h10 |=> regRdata[15:13] == 3'h0)
      else $error("pending bits survive disable");
   a_irq_drop: assert property (
      regWr && regAddr == 8'h10 && regWdata[12:10] == 3'h0
      |-> ##2 !genIrq[0] [*2])
      else $error("request stays after disable");

   c_event: cover property (eventTrigger);
   c_irq: cover property ($rose(genIrq[0]));
   c_dead: cover property (!pwmHigh[0] && !pwmLow[0]);
endmodule

bind smps_pwm_generator_core_regs smps_pwm_props u_props (
   .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .faultIn(faultIn),
   .limitIn(limitIn), .pwmHigh(pwmHigh), .pwmLow(pwmLow),
   .genIrq(genIrq), .eventTrigger(eventTrigger)
);

// >>> tb.sv
`timescale 1ns/100ps
module tb;
   logic clk;
   logic resetn;
   logic [7:0] regAddr;
   logic [15:0] regWdata;
   logic regWr;
   logic regRd;
   logic [15:0] regRdata;
   logic [1:0] faultIn, limitIn, pwmHigh, pwmLow, genIrq, faultCmd, limitCmd;
   logic eventTrigger, shootThrough, legOff;
   logic [15:0] rdv;
   int miscompares, n_checks, nHi, nEv, nLow, nBoth;
   logic [7:0] addrs[10] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h12, 8'h13,
      8'h23, 8'h21, 8'h35};
   logic [15:0] wvals[10] = '{16'hFFFF, 16'hFFFF, 16'hFFEF, 16'hFBFF, 16'hFFEF,
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFEF, 16'hFFFF};
   logic [15:0] exps[10] = '{16'hFFF8, 16'hFFF8, 16'hFFEF, 16'h1BC3, 16'hFFEF,
      16'hFFFC, 16'h3FFC, 16'h3FFC, 16'hFFEF, 16'h0000};
   logic [3:0] ps[3] = '{4'h0, 4'h1, 4'hF};

   smps_pwm_generator_core_regs DUT (.clk(clk), .resetn(resetn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .faultIn(faultIn), .limitIn(limitIn),
      .pwmHigh(pwmHigh), .pwmLow(pwmLow), .genIrq(genIrq),
      .eventTrigger(eventTrigger));
   power_stage_model stage (.clk(clk), .pwmHigh(pwmHigh), .pwmLow(pwmLow),
      .faultCmd(faultCmd), .limitCmd(limitCmd), .faultIn(faultIn),
      .limitIn(limitIn), .shootThrough(shootThrough), .legOff(legOff));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // bus and compare tasks
   // ----------------------------------------------------------------
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // write then read with no gap, as fast as the port allows
   task automatic wrrd(logic [7:0] a, logic [15:0] d);
      wr(a, d);
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      rdv = regRdata;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      rdv = regRdata;
   endtask
   task automatic measure(int n);
      nHi = 0;
      nEv = 0;
      nLow = 0;
      nBoth = 0;
      repeat (n) begin
         @(negedge clk);
         nHi += pwmHigh[0];
         nEv += eventTrigger;
         nLow += legOff;
         nBoth += shootThrough;
      end
   endtask
   task automatic end_sim();
      if (miscompares == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #100000;
      miscompares++;
      end_sim();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      regAddr = 8'h00;
      regWdata = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
      faultCmd = 2'h0;
      limitCmd = 2'h0;
      miscompares = 0;
      n_checks = 0;
      resetn = 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      foreach (addrs[i]) begin
         rd(addrs[i]);
         check(rdv, 16'h0000); // reset values
         wrrd(addrs[i], wvals[i]); // duties kept in range
         check(rdv, exps[i]);
      end
      // events every 17 cycles, postscaled
      wr(8'h00, 16'h0010);
      wr(8'h01, 16'h0008);
      foreach (ps[i]) begin
         wr(8'h03, {12'h000, ps[i]});
         measure(34 * (ps[i] + 1));
         check(16'(nEv), 16'h0002);
      end
      wr(8'h12, 16'h0000);
      wr(8'h13, 16'h0008);
      wr(8'h11, 16'h0008); // lowest legal duty
      wr(8'h02, 16'h000C);
      for (int s = 0; s < 2; s++) begin
         wr(8'h10, 16'h0080 | 16'(s << 8));
         repeat (40) @(posedge clk);
         measure(34);
         check(16'(nHi), s ? 16'd24 : 16'd16);
      end
      // leg 1 still inside its 4095-cycle positive dead time
      check({14'h0000, pwmHigh[1], pwmLow[1]}, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         wr(8'h10, {8'h00, 2'(m), 6'h00});
         repeat (40) @(posedge clk);
         measure(34);
         check(16'(nLow), m == 0 ? 16'd8 : 16'd0); // positive
         check(16'(nBoth), m == 1 ? 16'd8 : 16'd0); // negative
      end
      // bits 3:2 of the phase must not stretch the local period
      wr(8'h00, 16'h0028);
      wr(8'h12, 16'h001C);
      wr(8'h10, 16'h0280);
      repeat (60) @(posedge clk);
      measure(34);
      check(16'(nHi), 16'd16);
      for (int k = 0; k < 3; k++) begin
         wr(8'h10, 16'h1000 >> k);
         @(posedge clk);
         faultCmd <= {1'b0, k == 0};
         limitCmd <= {1'b0, k == 1};
         @(posedge clk);
         faultCmd <= 2'h0;
         limitCmd <= 2'h0;
         repeat (50) @(posedge clk);
         rd(8'h10);
         check(rdv, (16'h1000 >> k) | (16'h8000 >> k));
         check({14'h0000, genIrq}, 16'h0001);
         wrrd(8'h10, 16'h0000); // software clears status
         check(rdv, 16'h0000);
      end
      end_sim();
   end
endmodule
